// [rtl/gpio_port_pkg.sv]
// constants, register map and state layout of the port-b block with change interrupt
// Notes on behaviour
// RQ1 - eight pins: direction, latch, input each
// RQ2 - direction one floats pin; zero drives latch
// RQ3 - latch register reads back latched output
// RQ4 - port read gives pins; write sets latch
// RQ5 - active-low bit 7 enables all pull-ups
// RQ6 - output pins never get a pull-up
// RQ7 - reset: pull-ups off, all pins inputs
// RQ8 - only upper four input pins are compared
// RQ9 - mismatches ORed into flag, bit 0
// RQ10 - port access refreshes snapshot, except move
// RQ11 - persisting mismatch keeps setting the flag
// RQ12 - handler reads port, then clears flag
// RQ13 - enabled change interrupt wakes from sleep
// RQ14 - enable bit 3, priority second bit 0
// RQ15 - software avoids polling port during detection
// RQ16 - low-voltage programming on by default, pin 5
// RQ17 - programming mode removes pin 5 pull-up
// RQ18 - pins 0-2 irq inputs, 6-7 programming
// RQ19 - pin inputs synchronised before use
package gpio_port_pkg;
    localparam int unsigned PORT_W = 8;           // pins in the port
    localparam int unsigned CHG_LO = 4;           // lowest pin with change detect
    localparam int unsigned CHG_W = 4;            // pins with change detect
    localparam int unsigned EVT_W = 4;            // sticky event bits
    localparam int unsigned ADDR_W = 8;           // byte address width
    // register byte addresses
    localparam logic [7:0] OFF_PIN_LEVELS = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] OFF_DIRECTION = 8'h08;
    localparam logic [7:0] OFF_IC_MAIN = 8'h0C;
    localparam logic [7:0] OFF_IC_SECOND = 8'h10;
    localparam logic [7:0] OFF_IC_THIRD = 8'h14;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h18;
    localparam logic [7:0] OFF_EVT_CLEAR = 8'h1C;
    localparam logic [7:0] OFF_EVT_ENABLE = 8'h20;
    localparam logic [7:0] OFF_PIN_MOVE = 8'h24;  // port data reached by the move path
    localparam logic [7:0] OFF_CONFIG = 8'h28;
    // field positions
    localparam int unsigned CHG_FLAG_BIT = 0;     // main control: change flag
    localparam int unsigned CHG_EN_BIT = 3;       // main control: change enable
    localparam int unsigned CHG_PRIO_BIT = 0;     // second control: priority
    localparam int unsigned PULLUP_N_BIT = 7;     // second control: pull-up enable, low active
    localparam int unsigned LV_PIN = 5;           // pin taken by low-voltage programming
    localparam int unsigned PGC_PIN = 6;
    localparam int unsigned PGD_PIN = 7;
    localparam int unsigned EVT_CHG = 0;          // status: port change
    localparam int unsigned EVT_EXT0 = 1;         // status: ext inputs at bits 1..3
    // reset values and implemented-bit masks
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] IC_MAIN_RESET = 8'h00;
    localparam logic [7:0] IC_SECOND_RESET = 8'hF5;
    localparam logic [7:0] IC_SECOND_MASK = 8'hF5;
    localparam logic [7:0] IC_THIRD_RESET = 8'hC0;
    localparam logic [7:0] IC_THIRD_MASK = 8'hDB;
    localparam logic LVP_RESET = 1'b1;

    // whole state of the block
    typedef struct packed {
        logic [7:0] sync1;     // first synchroniser stage
        logic [7:0] sync2;
        logic [7:0] sync3;
        logic [7:0] stable;    // filtered pin levels
        logic [7:0] latch;
        logic [7:0] dir;
        logic [3:0] snap;      // upper pins at last port access
        logic [7:0] ic_main;
        logic [7:0] ic_second;
        logic [7:0] ic_third;
        logic [3:0] status;
        logic [3:0] enable;
        logic [2:0] ext_prev;  // previous ext input levels
        logic low_voltage_programming;
        logic ack;             // bus answer cycle
        logic [31:0] rdata;
    } state_t;
endpackage

// [rtl/gpio_port_b.sv]
// port-b general purpose i/o with change interrupt behind an avalon-mm slave
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module gpio_port_b #(
    parameter int unsigned PINS = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pullup_on,
    // alternate functions and system
    output logic ext_irq_in0,
    output logic ext_irq_in1,
    output logic ext_irq_in2,
    output logic serial_program_clock,
    output logic serial_program_data,
    output logic lv_program_enable_pin,
    output logic port_change_priority,
    input wire logic sleep_mode,
    output logic wake_request,
    output logic irq
);
    // the logic is written for exactly one eight-pin port
    generate
        if (PINS != gpio_port_pkg::PORT_W) begin : g_bad_width
            $error("gpio_port_b serves only eight pins");
        end
    endgenerate

    gpio_port_pkg::state_t q;       // registered state
    gpio_port_pkg::state_t next_q;  // value for the next edge
    logic req;                      // bus request present
    logic accept;                   // request completes this cycle
    logic wr_ok;                    // accepted write with low lane enabled
    logic port_access;              // access that refreshes the snapshot
    logic [3:0] change_mismatch;    // per upper pin mismatch
    logic [7:0] wbyte;              // write data low lane
    logic [3:0] evt_set;            // event pulses into status

    assign req = read | write;
    // one wait state: the first cycle fetches read data, the second answers
    assign accept = req & q.ack;
    assign waitrequest = req & ~q.ack;
    assign wr_ok = accept & write & byteenable[0];
    assign wbyte = writedata[7:0];
    // the move alias leaves the snapshot alone
    assign port_access = accept & (address == gpio_port_pkg::OFF_PIN_LEVELS); // RQ10
    // output pins are excluded from the comparison
    assign change_mismatch = (q.stable[7:4] ^ q.snap) & q.dir[7:4]; // RQ8
    assign evt_set = {q.stable[2:0] & ~q.ext_prev, |change_mismatch};

    // next-state logic
    always_comb begin
        next_q = q;
        // three stages; a change counts once stages two and three agree
        next_q.sync1 = pin_in; // RQ19
        next_q.sync2 = q.sync1;
        next_q.sync3 = q.sync2;
        for (int i = 0; i < gpio_port_pkg::PORT_W; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                next_q.stable[i] = q.sync3[i]; // RQ19
            end
        end
        next_q.ext_prev = q.stable[2:0];
        next_q.ack = req & ~q.ack;
        // read data is fetched in the wait cycle so it stands at the answer edge
        if (req & ~q.ack & read) begin
            unique case (address)
                gpio_port_pkg::OFF_PIN_LEVELS,
                gpio_port_pkg::OFF_PIN_MOVE: begin
                    next_q.rdata = {24'h000000, q.stable}; // RQ4
                end
                gpio_port_pkg::OFF_OUTPUT_LATCH: begin
                    next_q.rdata = {24'h000000, q.latch}; // RQ3
                end
                gpio_port_pkg::OFF_DIRECTION: begin
                    next_q.rdata = {24'h000000, q.dir};
                end
                gpio_port_pkg::OFF_IC_MAIN: begin
                    next_q.rdata = {24'h000000, q.ic_main};
                end
                gpio_port_pkg::OFF_IC_SECOND: begin
                    next_q.rdata = {24'h000000, q.ic_second};
                end
                gpio_port_pkg::OFF_IC_THIRD: begin
                    next_q.rdata = {24'h000000, q.ic_third};
                end
                gpio_port_pkg::OFF_EVT_STATUS: begin
                    next_q.rdata = {28'h0000000, q.status};
                end
                gpio_port_pkg::OFF_EVT_ENABLE: begin
                    next_q.rdata = {28'h0000000, q.enable};
                end
                gpio_port_pkg::OFF_CONFIG: begin
                    next_q.rdata = {31'h00000000, q.low_voltage_programming};
                end
                default: begin
                    // unmapped and write-only addresses read zero
                    next_q.rdata = 32'h00000000;
                end
            endcase
        end
        // register writes take effect on the answer edge
        if (wr_ok) begin
            unique case (address)
                gpio_port_pkg::OFF_PIN_LEVELS,
                gpio_port_pkg::OFF_PIN_MOVE,
                gpio_port_pkg::OFF_OUTPUT_LATCH: begin
                    next_q.latch = wbyte; // RQ4
                end
                gpio_port_pkg::OFF_DIRECTION: begin
                    next_q.dir = wbyte; // RQ2
                end
                gpio_port_pkg::OFF_IC_MAIN: begin
                    next_q.ic_main = wbyte; // RQ14
                end
                gpio_port_pkg::OFF_IC_SECOND: begin
                    next_q.ic_second = wbyte & gpio_port_pkg::IC_SECOND_MASK; // RQ5
                end
                gpio_port_pkg::OFF_IC_THIRD: begin
                    next_q.ic_third = wbyte & gpio_port_pkg::IC_THIRD_MASK;
                end
                gpio_port_pkg::OFF_EVT_CLEAR: begin
                    next_q.status = q.status & ~wbyte[3:0];
                end
                gpio_port_pkg::OFF_EVT_ENABLE: begin
                    next_q.enable = wbyte[3:0];
                end
                gpio_port_pkg::OFF_CONFIG: begin
                    next_q.low_voltage_programming = wbyte[0]; // RQ16
                end
                default: begin
                    // writes to read-only or unmapped words are dropped
                end
            endcase
        end
        // a read or write at the port address, not the move alias, takes a new snapshot, ending the mismatch
        if (port_access) begin
            next_q.snap = q.stable[7:4]; // RQ10
        end
        // a persisting mismatch sets the flag again over a software clear
        if (|change_mismatch) begin
            next_q.ic_main[gpio_port_pkg::CHG_FLAG_BIT] = 1'b1; // RQ9 RQ11
        end
        // new events win over the clear written in the same cycle
        next_q.status = next_q.status | evt_set;
    end

    // state register; clock enable freezes everything
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q.sync1 <= 8'h00;
            q.sync2 <= 8'h00;
            q.sync3 <= 8'h00;
            q.stable <= 8'h00;
            q.latch <= 8'h00;
            q.dir <= gpio_port_pkg::DIR_RESET; // RQ7
            q.snap <= 4'h0;
            q.ic_main <= gpio_port_pkg::IC_MAIN_RESET;
            q.ic_second <= gpio_port_pkg::IC_SECOND_RESET; // RQ7
            q.ic_third <= gpio_port_pkg::IC_THIRD_RESET;
            q.status <= 4'h0;
            q.enable <= 4'h0;
            q.ext_prev <= 3'h0;
            q.low_voltage_programming <= gpio_port_pkg::LVP_RESET; // RQ16
            q.ack <= 1'b0;
            q.rdata <= 32'h00000000;
        end else if (ce) begin
            q <= next_q;
        end
    end

    // pin drive: direction zero drives the latch; pin 5 is given up in programming mode
    always_comb begin
        pin_out = q.latch; // RQ1
        pin_oe = ~q.dir; // RQ2
        // pull-ups: global low-active bit, never on an output pin
        pullup_on = q.ic_second[gpio_port_pkg::PULLUP_N_BIT] ? 8'h00 : q.dir; // RQ5 RQ6
        if (q.low_voltage_programming) begin
            pin_oe[gpio_port_pkg::LV_PIN] = 1'b0; // RQ16
            pullup_on[gpio_port_pkg::LV_PIN] = 1'b0; // RQ17
        end
    end

    // alternate functions see the synchronised levels
    assign ext_irq_in0 = q.stable[0]; // RQ18
    assign ext_irq_in1 = q.stable[1]; // RQ18
    assign ext_irq_in2 = q.stable[2]; // RQ18
    assign serial_program_clock = q.stable[gpio_port_pkg::PGC_PIN]; // RQ18
    assign serial_program_data = q.stable[gpio_port_pkg::PGD_PIN]; // RQ18
    assign lv_program_enable_pin = q.low_voltage_programming & q.stable[gpio_port_pkg::LV_PIN];
    assign port_change_priority = q.ic_second[gpio_port_pkg::CHG_PRIO_BIT]; // RQ14
    // wake needs the enable as well as the flag
    assign wake_request = sleep_mode & q.ic_main[gpio_port_pkg::CHG_FLAG_BIT]
                          & q.ic_main[gpio_port_pkg::CHG_EN_BIT]; // RQ13
    assign irq = |(q.status & q.enable);
    assign readdata = q.rdata;

    // checks on the implemented behaviour
    a_flag_persist: // RQ11
    assert property (@(posedge clock) disable iff (!rst_n)
        (ce && (|change_mismatch)) |=> q.ic_main[gpio_port_pkg::CHG_FLAG_BIT])
    else $error("change flag not held by a persisting mismatch");

    a_snap_refresh: // RQ10
    assert property (@(posedge clock) disable iff (!rst_n)
        (ce && port_access) |=> (q.snap == $past(q.stable[7:4])))
    else $error("port access did not refresh the snapshot");

    a_move_keeps: // RQ10
    assert property (@(posedge clock) disable iff (!rst_n)
        (accept && address == gpio_port_pkg::OFF_PIN_MOVE) |=> $stable(q.snap))
    else $error("move path disturbed the snapshot");

    a_out_excluded: // RQ8
    assert property (@(posedge clock) disable iff (!rst_n)
        (q.dir[7:4] == 4'h0) |-> (change_mismatch == 4'h0))
    else $error("output pin took part in change compare");

    a_pullup_output: // RQ6
    assert property (@(posedge clock) disable iff (!rst_n)
        ((pullup_on & ~q.dir) == 8'h00))
    else $error("pull-up on an output pin");

    a_lvp_pin5: // RQ17
    assert property (@(posedge clock) disable iff (!rst_n)
        q.low_voltage_programming |-> (!pin_oe[gpio_port_pkg::LV_PIN] && !pullup_on[gpio_port_pkg::LV_PIN]))
    else $error("pin 5 active during programming mode");

    a_latch_write: // RQ4
    assert property (@(posedge clock) disable iff (!rst_n)
        (ce && wr_ok && address == gpio_port_pkg::OFF_PIN_LEVELS) |=> (pin_out == $past(wbyte)))
    else $error("port write did not reach the latch");

    a_one_wait: // RQ3
    assert property (@(posedge clock) disable iff (!rst_n)
        (ce && req && waitrequest) ##1 (ce && req) |-> !waitrequest)
    else $error("bus answer later than one wait state");

    a_sync_depth: // RQ19
    assert property (@(posedge clock) disable iff (!rst_n)
        (ce && q.sync2 != q.stable && q.sync2 == q.sync3) |=> (q.stable == $past(q.sync3)))
    else $error("agreed synchroniser value not taken");

    // a change event must land in the sticky status bit
    a_status_sticky: // RQ9
    assert property (@(posedge clock) disable iff (!rst_n)
        (ce && evt_set[gpio_port_pkg::EVT_CHG]) |=> q.status[gpio_port_pkg::EVT_CHG])
    else $error("change event lost from status");

    // outside programming mode every driver follows its direction bit
    a_oe_follows_dir: // RQ2
    assert property (@(posedge clock) disable iff (!rst_n)
        !q.low_voltage_programming |-> (pin_oe == ~q.dir))
    else $error("pin driver disagrees with direction");

    // the global low-active bit set means no pull-up anywhere
    a_pullup_global: // RQ5
    assert property (@(posedge clock) disable iff (!rst_n)
        q.ic_second[gpio_port_pkg::PULLUP_N_BIT] |-> (pullup_on == 8'h00))
    else $error("pull-up on while globally disabled");

    // wake only for an enabled, flagged change while asleep
    a_wake_gate: // RQ13
    assert property (@(posedge clock) disable iff (!rst_n)
        wake_request |-> (sleep_mode && q.ic_main[gpio_port_pkg::CHG_FLAG_BIT]
                          && q.ic_main[gpio_port_pkg::CHG_EN_BIT]))
    else $error("wake without enabled change flag");

    // latch read data is fetched in the wait cycle
    a_latch_fetch: // RQ3
    assert property (@(posedge clock) disable iff (!rst_n)
        (ce && req && !q.ack && read && address == gpio_port_pkg::OFF_OUTPUT_LATCH)
        |=> (readdata[7:0] == $past(q.latch)))
    else $error("latch read returned wrong data");

    // a direction write reaches the direction register
    a_dir_write: // RQ2
    assert property (@(posedge clock) disable iff (!rst_n)
        (ce && wr_ok && address == gpio_port_pkg::OFF_DIRECTION) |=> (q.dir == $past(wbyte)))
    else $error("direction write lost");
endmodule

// [dv/gpio_pins_model.sv]
// pin-side model of the port: keys on each line, weak pull-ups and lines left floating
`timescale 1ns/1ps
module gpio_pins_model (
    input wire logic clock,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] key_en,
    input wire logic [7:0] key_val,
    output logic [7:0] pin_in
);
    logic [7:0] float_pat = 8'h55; // an undriven line wanders, so a stale level never passes for data
    // floating pattern flips every cycle
    always @(posedge clock) begin
        float_pat <= ~float_pat;
    end
    // each line: the port's driver wins, then a pressed key, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (key_en[i])
                pin_in[i] = key_val[i];
            else if (pullup_on[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_pat[i];
        end
    end
endmodule

// [dv/gpio_port_b_with_change_irq_bench.sv]
// self-checking bench of the port-b block: register rows, then pins, pull-ups and change cases
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module gpio_port_b_with_change_irq_bench;
    typedef struct packed {
        logic [7:0] a; // byte address
        logic wr; // write when high
        logic be; // low lane enable
        logic [7:0] d; // write data or expected read
    } row_t;
    logic clock, rst_n, read, write, sleep_mode, e0, prio, wake, irq, waitrequest;
    logic [7:0] address, pin_in, pin_out, pin_oe, pullup_on, key_en, key_val, q;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    int n_mismatch = 0;
    int checks = 0;
    row_t rows [16] = '{
        '{8'h08, 1'b0, 1'b1, 8'hFF},
        '{8'h0C, 1'b0, 1'b1, 8'h00},
        '{8'h10, 1'b0, 1'b1, 8'hF5},
        '{8'h14, 1'b0, 1'b1, 8'hC0}, '{8'h18, 1'b0, 1'b1, 8'h00}, '{8'h20, 1'b0, 1'b1, 8'h00},
        '{8'h28, 1'b0, 1'b1, 8'h01},
        '{8'h30, 1'b0, 1'b1, 8'h00}, // unmapped place reads zero
        '{8'h04, 1'b1, 1'b1, 8'h5A}, '{8'h04, 1'b0, 1'b1, 8'h5A},
        '{8'h04, 1'b1, 1'b0, 8'h11}, '{8'h04, 1'b0, 1'b1, 8'h5A},
        '{8'h14, 1'b1, 1'b1, 8'hFF}, '{8'h14, 1'b0, 1'b1, 8'hDB},
        '{8'h18, 1'b1, 1'b1, 8'hFF}, '{8'h18, 1'b0, 1'b1, 8'h00}
    };
    gpio_port_b DUT (.clock(clock), .rst_n(rst_n), .ce(1'b1), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_irq_in0(e0), .ext_irq_in1(), .ext_irq_in2(),
        .serial_program_clock(), .serial_program_data(), .lv_program_enable_pin(),
        .port_change_priority(prio), .sleep_mode(sleep_mode), .wake_request(wake), .irq(irq));
    gpio_pins_model pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .key_en(key_en), .key_val(key_val), .pin_in(pin_in));
    // one avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [7:0] a, input logic wr, input logic be, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, d};
        byteenable <= {3'h0, be};
        // look mid-cycle, where waitrequest and readdata have settled for the coming edge
        do begin
            @(negedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40) `CHK("bus answer", 1'b0, waitrequest)
        q = readdata[7:0];
        // the answer edge: the transfer completes here, only then is it released
        @(posedge clock);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(a, 1'b0, 1'b1, 8'h00);
    endtask
    // pins cross a synchroniser of several stages, so allow them time to land
    task automatic settle();
        repeat (8) @(posedge clock);
    endtask
    // bounded wait for the interrupt line; polls irq, never the port data
    task automatic wait_irq();
        for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clock);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // 10 MHz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clock);
        `CHK("watchdog", 1'b0, 1'b1)
        tally_and_finish();
    end
    // main sequence
    initial begin
        {rst_n, read, write, sleep_mode, address, writedata, byteenable} = '0;
        key_en = 8'hFF;
        key_val = 8'h00;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        `CHK("reset oe", 8'h00, pin_oe)
        `CHK("reset pullup", 8'h00, pullup_on)
        foreach (rows[i]) begin
            bus(rows[i].a, rows[i].wr, rows[i].be, rows[i].d);
            if (!rows[i].wr) `CHK("register", rows[i].d, q)
        end
        $display("test rows done");
        // low pins drive the latch, upper pins read the keys
        wr(8'h08, 8'hF0);
        wr(8'h00, 8'hA5);
        key_val <= 8'h30;
        settle();
        `CHK("pin_oe", 8'h0F, pin_oe)
        `CHK("pin_out", 8'hA5, pin_out)
        rd(8'h00);
        `CHK("port read", 8'h35, q)
        rd(8'h04);
        `CHK("latch read", 8'hA5, q)
        $display("test pins done");
        // pull-ups on inputs only, pin 5 held off while low-voltage programming is on
        key_en <= 8'h00;
        wr(8'h10, 8'h75);
        settle();
        `CHK("pullup lvp", 8'hD0, pullup_on)
        `CHK("priority", 1'b1, prio)
        wr(8'h28, 8'h00);
        settle();
        `CHK("pullup", 8'hF0, pullup_on)
        key_en <= 8'hFF;
        key_val <= 8'h00;
        settle();
        $display("test pullups done");
        // change on pin 6 sets the flag, which a clear cannot end while the mismatch lasts
        rd(8'h00);
        wr(8'h1C, 8'h0F);
        wr(8'h0C, 8'h08);
        wr(8'h20, 8'h01);
        sleep_mode <= 1'b1;
        key_val <= 8'h40;
        wait_irq();
        `CHK("irq", 1'b1, irq)
        `CHK("wake", 1'b1, wake)
        wr(8'h0C, 8'h08);
        rd(8'h0C);
        `CHK("flag held", 8'h09, q)
        rd(8'h24);
        `CHK("move read", 8'h45, q)
        wr(8'h1C, 8'h01);
        @(posedge clock);
        `CHK("move keeps", 1'b1, irq)
        rd(8'h00);
        wr(8'h1C, 8'h01);
        wr(8'h0C, 8'h08);
        rd(8'h0C);
        `CHK("flag cleared", 8'h08, q)
        `CHK("irq low", 1'b0, irq)
        `CHK("wake low", 1'b0, wake)
        sleep_mode <= 1'b0;
        $display("test change done");
        // an upper pin set as output toggles without raising the flag
        wr(8'h08, 8'h70);
        settle();
        rd(8'h00);
        wr(8'h04, 8'h25);
        settle();
        rd(8'h0C);
        `CHK("output excluded", 8'h08, q)
        `CHK("irq quiet", 1'b0, irq)
        $display("test outputs done");
        // rising level on pin 0 reaches the external interrupt path
        wr(8'h08, 8'hFF);
        settle();
        rd(8'h00);
        wr(8'h1C, 8'h0F);
        wr(8'h20, 8'h02);
        key_val <= 8'h41;
        wait_irq();
        `CHK("ext in0", 1'b1, e0)
        rd(8'h18);
        `CHK("ext status", 8'h02, q)
        $display("test ext done");
        // reset again in mid-run: direction back to all inputs
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        `CHK("rerun oe", 8'h00, pin_oe)
        rd(8'h08);
        `CHK("rerun dir", 8'hFF, q)
        $display("test reset done");
        tally_and_finish();
    end
endmodule
